// ===== logic/csf_regs.vh
// register offsets, field positions, reset values and rate constants of the sinc3 datapath
`ifndef CSF_REGS_VH
`define CSF_REGS_VH
`define CSF_OFS_RATE 8'h00
`define CSF_OFS_GAIN 8'h04
`define CSF_OFS_FILT 8'h08
`define CSF_OFS_STAT 8'h0C
`define CSF_RATE_SEL_LSB 0
`define CSF_MIXED_BIT 2
`define CSF_GAIN_LSB 0
`define CSF_BYP_BIT 5
`define CSF_OVR_BIT 0
`define CSF_PEND_BIT 1
`define CSF_LEVEL_LSB 4
`define CSF_RATE_RST 2'h0
`define CSF_MIXED_RST 1'b0
`define CSF_GAIN_RST 3'h0
`define CSF_BYP_RST 1'b0
`define CSF_MOD_DIV_M1 3'h7
`define CSF_LOG2N_BASE 5'h05
`define CSF_ADC_W 24
`define CSF_DATA_FLAG 1'b0
`define CSF_RESP_OKAY 2'h0
`define CSF_RESP_SLVERR 2'h2
`endif

// ===== logic/csf_top.v
// sinc3 decimator, sinc3 interpolator and dac sigma-delta modulator of one codec channel
// Operation
// - adc modulator bit taken once per eight device master clocks feeds the decimator
// - decimator is three integrators and three combs, n is the oversampling ratio
// - at n=32 one adc word per 32 modulator bits, device master clock over 256
// - at n=32 each stage grows the word by five bits
// - at n=32 the 16-bit data mode word carries one zero lsb
// - slower rates grow the word up to 24 bits at n=256, then truncated
// - adc result two's complement, data mode sends the top 16 bits
// - mixed mode sends a flag msb and 15 sample bits
// - dac samples are two's complement, 7FFF positive and 8000 negative full scale
// - interpolator is sinc3 with the same n, up to master clock over eight
// - one dac sample per period, previous sample reused when none arrives
// - bypass bit 5 of the filter control register skips the interpolator
// - second order sigma-delta turns 16-bit values into one bit per modulator tick
// - gain field bits 0 to 2 select 0 to 38 db encoder gain
// - device master clock is the core clock divided by an on-chip divider
// - rate select field of two bits picks one of four sample rates
`timescale 1ns/1ps
`include "csf_regs.vh"

module csf_fifo #(
   parameter W = 16,
   parameter D = 8,
   parameter AW = 3
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // fill side
   input wire [W-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   // drain side
   output wire [W-1:0] out_data,
   output wire out_valid,
   input wire out_ready,
   // fill level
   output wire [AW:0] level
);
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wr_reg;
   reg [AW-1:0] rd_reg;
   reg [AW:0] cnt_reg;
   wire push;
   wire pop;
   assign in_ready = (cnt_reg != D[AW:0]);
   assign out_valid = (cnt_reg != {(AW+1){1'b0}});
   assign out_data = mem[rd_reg];
   assign level = cnt_reg;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always @(posedge clk)
   begin
      if (push)
         mem[wr_reg] <= in_data;
   end
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_reg <= {AW{1'b0}};
         rd_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_reg <= (wr_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
         if (pop)
            rd_reg <= (rd_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
         if (push & ~pop)
            cnt_reg <= cnt_reg + 1'b1;
         else if (pop & ~push)
            cnt_reg <= cnt_reg - 1'b1;
      end
   end
endmodule

module csf_top #(
   parameter MCLK_DIV = 2,
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   // clock and reset
   input wire CORE_CLK,
   input wire RST_N,
   // axi4-lite write address and data
   input wire [7:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   // axi4-lite write response
   output wire [1:0] S_AXI_BRESP,
   output wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   // axi4-lite read
   input wire [7:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   output wire [31:0] S_AXI_RDATA,
   output wire [1:0] S_AXI_RRESP,
   output wire S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // encoder side
   input wire ADC_MOD_BIT,
   output wire [2:0] INPUT_GAIN_SEL,
   output wire [15:0] ADC_WORD,
   output wire ADC_VALID,
   input wire ADC_READY,
   // decoder side
   input wire [15:0] DAC_WORD,
   input wire DAC_VALID,
   output wire DAC_READY,
   output wire DAC_BIT,
   // rate strobes
   output wire MOD_TICK,
   output wire SAMPLE_TICK
);
   reg [7:0] dm_cnt_reg;
   reg [2:0] mod_cnt_reg;
   reg [7:0] dec_cnt_reg;
   reg [1:0] rate_reg;
   reg mixed_reg;
   reg [2:0] gain_reg;
   reg byp_reg;
   reg ovr_reg;
   reg ovr_next;
   reg aw_held_reg;
   reg [7:0] aw_addr_reg;
   reg w_held_reg;
   reg [31:0] w_data_reg;
   reg w_strb0_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   reg rvalid_reg;
   reg [31:0] rdata_reg;
   reg [1:0] rresp_reg;
   reg [24:0] i1_reg;
   reg [24:0] i2_reg;
   reg [24:0] i3_reg;
   reg [24:0] d1_reg;
   reg [24:0] d2_reg;
   reg [24:0] d3_reg;
   reg [15:0] adc_word_reg;
   reg adc_pend_reg;
   reg [15:0] dac_latest_reg;
   reg [15:0] dac_cur_reg;
   reg signed [33:0] p1_reg;
   reg signed [33:0] p2_reg;
   reg signed [33:0] p3_reg;
   reg signed [33:0] j1_reg;
   reg signed [33:0] j2_reg;
   reg signed [33:0] j3_reg;
   reg [15:0] interp_reg;
   reg signed [21:0] v1_reg;
   reg signed [21:0] v2_reg;
   reg dac_bit_reg;
   wire dm_tick;
   wire mod_tick;
   wire dec_tick;
   wire [24:0] c1;
   wire [24:0] c2;
   wire [24:0] c3;
   wire [24:0] half;
   wire [24:0] ctr;
   wire [24:0] ctr_sat;
   wire [24:0] left;
   wire [23:0] res24;
   wire [15:0] adc_new;
   wire fifo_in_ready;
   wire [FIFO_AW:0] fifo_level;
   wire signed [33:0] x34;
   wire signed [33:0] e1;
   wire signed [33:0] e2;
   wire signed [33:0] e3;
   wire signed [33:0] add_v;
   wire signed [33:0] j3_new;
   wire signed [33:0] shifted;
   wire [15:0] dsm_in;
   wire signed [21:0] x22;
   wire signed [21:0] fb;
   wire signed [21:0] v1_new;
   wire signed [21:0] v2_new;
   wire wr_go;
   wire wr_hit;
   wire ar_go;

   // log2 of the oversampling ratio
   function [4:0] log2n;
      input [1:0] rs;
      log2n = `CSF_LOG2N_BASE + {3'h0, rs};
   endfunction

   // last count of the decimation period
   function [7:0] n_minus1;
      input [1:0] rs;
      reg [8:0] t;
      begin
         t = (9'h020 << rs) - 9'h001;
         n_minus1 = t[7:0];
      end
   endfunction

   // clip a loop state to +/-(2^20-1); two clipped states plus feedback still fit in 22 bits
   function signed [21:0] clip22;
      input signed [21:0] v;
      begin
         if (v > 22'sh0FFFFF)
            clip22 = 22'sh0FFFFF;
         else if (v < -22'sh0FFFFF)
            clip22 = -22'sh0FFFFF;
         else
            clip22 = v;
      end
   endfunction

   // divide the core clock down to the device master clock and modulator rate
   always @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         dm_cnt_reg <= 8'h00;
         mod_cnt_reg <= 3'h0;
         dec_cnt_reg <= 8'h00;
      end
      else
      begin
         dm_cnt_reg <= dm_tick ? 8'h00 : dm_cnt_reg + 8'h01;
         if (dm_tick)
            mod_cnt_reg <= mod_cnt_reg + 3'h1;
         if (mod_tick)
            dec_cnt_reg <= dec_tick ? 8'h00 : dec_cnt_reg + 8'h01;
      end
   end
   assign dm_tick = (dm_cnt_reg == MCLK_DIV[7:0] - 8'h01);
   assign mod_tick = dm_tick & (mod_cnt_reg == `CSF_MOD_DIV_M1);
   assign dec_tick = mod_tick & (dec_cnt_reg == n_minus1(rate_reg));
   assign MOD_TICK = mod_tick;
   assign SAMPLE_TICK = dec_tick;

   // decimator: integrators at the modulator rate, combs at the output rate
   always @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         i1_reg <= 25'h0000000;
         i2_reg <= 25'h0000000;
         i3_reg <= 25'h0000000;
         d1_reg <= 25'h0000000;
         d2_reg <= 25'h0000000;
         d3_reg <= 25'h0000000;
      end
      else
      begin
         if (mod_tick)
         begin
            i1_reg <= i1_reg + {24'h000000, ADC_MOD_BIT};
            i2_reg <= i2_reg + i1_reg;
            i3_reg <= i3_reg + i2_reg;
         end
         if (dec_tick)
         begin
            d1_reg <= i3_reg;
            d2_reg <= c1;
            d3_reg <= c2;
         end
      end
   end
   // modulo arithmetic: integrator wrap cancels in the combs
   assign c1 = i3_reg - d1_reg;
   assign c2 = c1 - d2_reg;
   assign c3 = c2 - d3_reg;
   // grown word is 3*log2n bits; centre it to two's complement around n^3/2
   assign half = 25'h0000001 << (5'd3 * log2n(rate_reg) - 5'd1);
   assign ctr = c3 - half;
   assign ctr_sat = (c3 == {half[23:0], 1'b0}) ? half - 25'h0000001 : ctr;
   assign left = ctr_sat << (5'd24 - 5'd3 * log2n(rate_reg));
   assign res24 = left[`CSF_ADC_W-1:0];
   // top bits only, no rounding; at n=32 the low bit comes out zero in data mode
   assign adc_new = mixed_reg ? {`CSF_DATA_FLAG, res24[23:9]}
                              : res24[23:8];

   // hold one word for the fifo; a word not yet taken at the next period is lost
   always @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         adc_word_reg <= 16'h0000;
         adc_pend_reg <= 1'b0;
         ovr_reg <= 1'b0;
      end
      else
      begin
         ovr_reg <= ovr_next;
         if (dec_tick)
         begin
            adc_word_reg <= adc_new;
            adc_pend_reg <= 1'b1;
         end
         else if (fifo_in_ready)
            adc_pend_reg <= 1'b0;
      end
   end
   // overrun set wins over a software clear in the same cycle
   always @*
   begin
      ovr_next = ovr_reg;
      if (wr_hit && aw_addr_reg == `CSF_OFS_STAT && w_data_reg[`CSF_OVR_BIT])
         ovr_next = 1'b0;
      if (dec_tick && adc_pend_reg && !fifo_in_ready)
         ovr_next = 1'b1;
   end

   csf_fifo #(
      .W(16),
      .D(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .in_data(adc_word_reg),
      .in_valid(adc_pend_reg),
      .in_ready(fifo_in_ready),
      .out_data(ADC_WORD),
      .out_valid(ADC_VALID),
      .out_ready(ADC_READY),
      .level(fifo_level)
   );

   // dac sample: latest word from the host, taken up once per period
   assign DAC_READY = 1'b1;
   always @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         dac_latest_reg <= 16'h0000;
         dac_cur_reg <= 16'h0000;
      end
      else
      begin
         if (DAC_VALID)
            dac_latest_reg <= DAC_WORD;
         if (dec_tick)
            dac_cur_reg <= dac_latest_reg;
      end
   end

   // interpolator: combs at the sample rate, zero-stuffed integrators at modulator rate
   assign x34 = {{18{dac_cur_reg[15]}}, dac_cur_reg};
   assign e1 = x34 - p1_reg;
   assign e2 = e1 - p2_reg;
   assign e3 = e2 - p3_reg;
   assign add_v = dec_tick ? e3 : 34'sh000000000;
   assign j3_new = j3_reg + j2_reg;
   // gain of the interpolator is n^2, removed by an arithmetic shift
   assign shifted = j3_new >>> {log2n(rate_reg), 1'b0};
   always @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         p1_reg <= 34'sh000000000;
         p2_reg <= 34'sh000000000;
         p3_reg <= 34'sh000000000;
         j1_reg <= 34'sh000000000;
         j2_reg <= 34'sh000000000;
         j3_reg <= 34'sh000000000;
         interp_reg <= 16'h0000;
      end
      else
      begin
         if (dec_tick)
         begin
            p1_reg <= x34;
            p2_reg <= e1;
            p3_reg <= e2;
         end
         if (mod_tick)
         begin
            j1_reg <= j1_reg + add_v;
            j2_reg <= j2_reg + j1_reg;
            j3_reg <= j3_new;
            interp_reg <= shifted[15:0];
         end
      end
   end
   assign dsm_in = byp_reg ? dac_cur_reg : interp_reg;

   // second order sigma-delta; states are clipped since a full-scale input winds the loop past 22 bits
   assign x22 = {{6{dsm_in[15]}}, dsm_in};
   assign fb = dac_bit_reg ? 22'sh008000 : -22'sh008000;
   assign v1_new = clip22(v1_reg + x22 - fb);
   // second stage takes the fresh first-stage value, giving a noise transfer of (1-z^-1)^2
   assign v2_new = clip22(v2_reg + v1_new - fb);
   always @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         v1_reg <= 22'sh000000;
         v2_reg <= 22'sh000000;
         dac_bit_reg <= 1'b0;
      end
      else if (mod_tick)
      begin
         v1_reg <= v1_new;
         v2_reg <= v2_new;
         dac_bit_reg <= ~v2_new[21];
      end
   end
   assign DAC_BIT = dac_bit_reg;
   assign INPUT_GAIN_SEL = gain_reg;

   // axi4-lite slave: address and data latched independently
   assign S_AXI_AWREADY = ~aw_held_reg;
   assign S_AXI_WREADY = ~w_held_reg;
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP = bresp_reg;
   assign S_AXI_ARREADY = ~rvalid_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RDATA = rdata_reg;
   assign S_AXI_RRESP = rresp_reg;
   assign wr_go = aw_held_reg & w_held_reg & ~bvalid_reg;
   assign wr_hit = wr_go & w_strb0_reg;
   assign ar_go = S_AXI_ARVALID & ~rvalid_reg;
   always @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb0_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `CSF_RESP_OKAY;
         rate_reg <= `CSF_RATE_RST;
         mixed_reg <= `CSF_MIXED_RST;
         gain_reg <= `CSF_GAIN_RST;
         byp_reg <= `CSF_BYP_RST;
      end
      else
      begin
         if (S_AXI_AWVALID & ~aw_held_reg)
         begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= {S_AXI_AWADDR[7:2], 2'h0};
         end
         if (S_AXI_WVALID & ~w_held_reg)
         begin
            w_held_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb0_reg <= S_AXI_WSTRB[0];
         end
         if (wr_go)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= `CSF_RESP_OKAY;
            case (aw_addr_reg)
               `CSF_OFS_RATE:
               begin
                  if (w_strb0_reg)
                  begin
                     rate_reg <= w_data_reg[`CSF_RATE_SEL_LSB+1:`CSF_RATE_SEL_LSB];
                     mixed_reg <= w_data_reg[`CSF_MIXED_BIT];
                  end
               end
               `CSF_OFS_GAIN:
               begin
                  if (w_strb0_reg)
                     gain_reg <= w_data_reg[`CSF_GAIN_LSB+2:`CSF_GAIN_LSB];
               end
               `CSF_OFS_FILT:
               begin
                  if (w_strb0_reg)
                     byp_reg <= w_data_reg[`CSF_BYP_BIT];
               end
               `CSF_OFS_STAT:
                  bresp_reg <= `CSF_RESP_OKAY;
               default:
                  bresp_reg <= `CSF_RESP_SLVERR;
            endcase
         end
         else if (bvalid_reg & S_AXI_BREADY)
            bvalid_reg <= 1'b0;
      end
   end

   // read side: one cycle from address to data
   always @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `CSF_RESP_OKAY;
      end
      else if (ar_go)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg <= `CSF_RESP_OKAY;
         rdata_reg <= 32'h00000000;
         case ({S_AXI_ARADDR[7:2], 2'h0})
            `CSF_OFS_RATE:
               rdata_reg <= {29'h00000000, mixed_reg, rate_reg};
            `CSF_OFS_GAIN:
               rdata_reg <= {29'h00000000, gain_reg};
            `CSF_OFS_FILT:
               rdata_reg <= {26'h0000000, byp_reg, 5'h00};
            `CSF_OFS_STAT:
               rdata_reg <= {{(28-FIFO_AW-1){1'b0}}, fifo_level, 2'h0, adc_pend_reg, ovr_reg};
            default:
               rresp_reg <= `CSF_RESP_SLVERR;
         endcase
      end
      else if (rvalid_reg & S_AXI_RREADY)
         rvalid_reg <= 1'b0;
   end
endmodule

// ===== dv/csf_properties.sv
// checker of tick spacing, bus holds and stream holds of the sinc3 datapath
`timescale 1ns/1ps
module csf_properties #(
   parameter MCLK_DIV = 2
) (
   // clock and reset
   input wire CORE_CLK,
   input wire RST_N,
   // register bus
   input wire S_AXI_ARVALID,
   input wire S_AXI_ARREADY,
   input wire S_AXI_RVALID,
   input wire S_AXI_RREADY,
   input wire [31:0] S_AXI_RDATA,
   input wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [1:0] S_AXI_BRESP,
   // streams
   input wire [2:0] INPUT_GAIN_SEL,
   input wire [15:0] ADC_WORD,
   input wire ADC_VALID,
   input wire ADC_READY,
   input wire DAC_READY,
   input wire DAC_BIT,
   input wire MOD_TICK,
   input wire SAMPLE_TICK
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   reg [15:0] gap_reg;
   reg seen_reg;
   // the first tick after reset has no predecessor, so spacing is judged from the second
   always @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         gap_reg <= 16'h0000;
         seen_reg <= 1'b0;
      end
      else if (MOD_TICK)
      begin
         gap_reg <= 16'h0000;
         seen_reg <= 1'b1;
      end
      else
         gap_reg <= gap_reg + 16'h0001;
   end
   mod_tick_gap_a: assert property (MOD_TICK && seen_reg |-> gap_reg == 8 * MCLK_DIV - 1)
      else $error("modulator tick spacing off");
   mod_tick_due_a: assert property (seen_reg && !MOD_TICK |-> gap_reg < 8 * MCLK_DIV - 1)
      else $error("modulator tick missing");
   sample_on_mod_a: assert property (SAMPLE_TICK |-> MOD_TICK)
      else $error("sample tick off the modulator grid");
   dac_bit_pace_a: assert property ($changed(DAC_BIT) |-> $past(MOD_TICK))
      else $error("dac bit moved between ticks");
   gain_by_write_a: assert property ($changed(INPUT_GAIN_SEL) |-> $rose(S_AXI_BVALID))
      else $error("gain select moved without a write");
   adc_launch_a: assert property ($rose(ADC_VALID) |-> $past(SAMPLE_TICK, 2))
      else $error("adc word out of step with sample tick");
   adc_hold_a: assert property (ADC_VALID && !ADC_READY |=> ADC_VALID && $stable(ADC_WORD))
      else $error("adc word dropped before pop");
   dac_ready_a: assert property (DAC_READY)
      else $error("dac input refused");
   read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   read_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data not held");
   write_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response not held");
   cover property (SAMPLE_TICK);
   cover property ($rose(ADC_VALID));
   cover property (ADC_VALID && !ADC_READY);
endmodule

bind csf_top csf_properties #(.MCLK_DIV(MCLK_DIV)) u_chk (.*);

// ===== dv/csf_host.sv
// host partner: pops adc words and sends one dac word per sample period
`timescale 1ns/1ps
module csf_host (
   // clock and reset
   input wire clk,
   input wire rst_n,
   input wire sample_tick,
   // adc words in
   input wire [15:0] adc_word,
   input wire adc_valid,
   output reg adc_ready,
   // dac words out
   output reg [15:0] dac_word,
   output reg dac_valid,
   // bench control and view
   input wire stall,
   input wire dac_on,
   input wire [15:0] dac_val,
   output reg [15:0] last_adc,
   output reg [15:0] adc_cnt
);
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         adc_ready <= 1'b0;
         dac_word <= 16'h0000;
         dac_valid <= 1'b0;
         last_adc <= 16'h0000;
         adc_cnt <= 16'h0000;
      end
      else
      begin
         adc_ready <= !stall;
         if (adc_valid && adc_ready)
         begin
            last_adc <= adc_word;
            adc_cnt <= adc_cnt + 16'h0001;
         end
         // one word per period; when silent the bus toggles so a stale word is never reused by luck
         dac_valid <= dac_on && sample_tick;
         dac_word <= (dac_on && sample_tick) ? dac_val : ~dac_word;
      end
   end
endmodule

// ===== dv/codec_sinc3_filter_datapath_tb.sv
// self-checking bench of the sinc3 datapath with a host partner
`timescale 1ns/1ps
module codec_sinc3_filter_datapath_tb;
   reg clk, rst_n, awv, wv, arv, mbit, alt, stall, dac_on, brdy, rrdy;
   reg [7:0] awaddr, araddr;
   reg [31:0] wdata;
   reg [15:0] dac_val;
   wire awready, wready, bvalid, arready, rvalid, av, ar, dv, dr, dbit, mt, st;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [2:0] gs;
   wire [15:0] aw, dw, last, cnt;
   integer failures, cmp_count;
   csf_top #(.MCLK_DIV(1)) dut (.CORE_CLK(clk), .RST_N(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(brdy), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rrdy), .ADC_MOD_BIT(mbit), .INPUT_GAIN_SEL(gs), .ADC_WORD(aw), .ADC_VALID(av),
      .ADC_READY(ar), .DAC_WORD(dw), .DAC_VALID(dv), .DAC_READY(dr), .DAC_BIT(dbit),
      .MOD_TICK(mt), .SAMPLE_TICK(st));
   csf_host host (.clk(clk), .rst_n(rst_n), .sample_tick(st), .adc_word(aw), .adc_valid(av),
      .adc_ready(ar), .dac_word(dw), .dac_valid(dv), .stall(stall), .dac_on(dac_on),
      .dac_val(dac_val), .last_adc(last), .adc_cnt(cnt));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // modulator stand-in: all zeros or alternating ones and zeros
   always @(posedge clk)
      if (mt)
         mbit <= alt ? ~mbit : 1'b0;
   task chk(input string nm, input [31:0] e, input [31:0] g);
   begin
      cmp_count = cmp_count + 1;
      if (g !== e)
      begin
         failures = failures + 1;
         $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
   end
   endtask
   task wr(input [7:0] a, input [31:0] d, output [1:0] r);
      integer n;
   begin
      n = 0;
      r = 2'h3;
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      while (r === 2'h3 && n < 100)
      begin
         @(posedge clk);
         n = n + 1;
         if (awv && awready)
            awv <= 1'b0;
         if (wv && wready)
            wv <= 1'b0;
         if (bvalid && brdy)
            r = bresp;
      end
      if (n >= 100)
         failures = failures + 1;
   end
   endtask
   task rd(input [7:0] a, output [31:0] d, output [1:0] r);
      integer n;
   begin
      n = 0;
      r = 2'h3;
      araddr <= a;
      arv <= 1'b1;
      while (r === 2'h3 && n < 100)
      begin
         @(posedge clk);
         n = n + 1;
         if (arv && arready)
            arv <= 1'b0;
         if (rvalid && rrdy)
         begin
            d = rdata;
            r = rresp;
         end
      end
      if (n >= 100)
         failures = failures + 1;
   end
   endtask
   task t_reset;
      reg [1:0] r;
      reg [31:0] d;
      integer i;
   begin
      for (i = 0; i < 3; i = i + 1)
      begin
         rd(i * 4, d, r);
         chk("reset value", 32'h0, d);
      end
      rd(8'hF0, d, r);
      chk("unmapped read", 32'h2, {d[29:0], r});
      wr(8'hF0, 32'h1, r);
      chk("unmapped write", 32'h2, r);
      // answers held back by a late ready must stand until taken
      rrdy <= 1'b0;
      brdy <= 1'b0;
      fork
         rd(8'h04, d, r);
         begin
            repeat (3) @(posedge clk);
            rrdy <= 1'b1;
         end
      join
      chk("held read data", 32'h0, d);
      chk("held read resp", 32'h0, r);
      fork
         wr(8'h08, 32'h0, r);
         begin
            repeat (3) @(posedge clk);
            brdy <= 1'b1;
         end
      join
      chk("held write resp", 32'h0, r);
   end
   endtask
   task t_gain;
      reg [1:0] r;
      reg [31:0] d;
      integer g;
   begin
      for (g = 0; g < 8; g = g + 1)
      begin
         wr(8'h04, g, r);
         chk("gain pins", g, gs);
         rd(8'h04, d, r);
         chk("gain reg", g, d);
      end
   end
   endtask
   task nxt(output [15:0] w);
      integer n;
      reg [15:0] c;
   begin
      c = cnt;
      n = 0;
      while (cnt === c && n < 3000)
      begin
         @(posedge clk);
         n = n + 1;
      end
      if (n >= 3000)
         failures = failures + 1;
      w = last;
   end
   endtask
   // early words are filter transients, so four periods pass before judging
   task t_adc(input [1:0] rs, input mx, input al, input [15:0] e);
      reg [1:0] r;
      reg [15:0] w;
      integer p;
   begin
      wr(8'h00, {29'h0, mx, rs}, r);
      alt <= al;
      repeat (1024 << rs) @(posedge clk);
      nxt(w);
      nxt(w);
      chk("adc word", e, w);
      p = 0;
      while (!st && p < 5000)
      begin
         @(posedge clk);
         p = p + 1;
      end
      p = 0;
      do
      begin
         @(posedge clk);
         p = p + 1;
      end
      while (!st && p < 5000);
      chk("sample period", 256 << rs, p);
   end
   endtask
   task t_fifo;
      reg [1:0] r;
      reg [31:0] d;
      integer n;
   begin
      wr(8'h00, 32'h0, r);
      stall <= 1'b1;
      repeat (11 * 256) @(posedge clk);
      rd(8'h0C, d, r);
      chk("overrun and level", 32'h81, d & 32'hF1);
      stall <= 1'b0;
      n = 0;
      while (av && n < 20)
      begin
         @(posedge clk);
         n = n + 1;
      end
      chk("drained", 32'h0, av);
      wr(8'h0C, 32'h1, r);
      rd(8'h0C, d, r);
      chk("overrun cleared", 32'h0, d[0]);
   end
   endtask
   task t_dac(input b, input [15:0] v, input hi);
      reg [1:0] r;
      integer k, ones;
   begin
      wr(8'h08, {26'h0, b, 5'h0}, r);
      dac_val <= v;
      dac_on <= 1'b1;
      repeat (1536) @(posedge clk);
      dac_on <= 1'b0;
      repeat (256) @(posedge clk);
      ones = 0;
      k = 0;
      while (k < 64)
      begin
         @(posedge clk);
         if (mt)
         begin
            k = k + 1;
            ones = ones + dbit;
         end
      end
      chk("dac density", 32'h1, hi ? ones > 48 : ones < 16);
   end
   endtask
   task conclude;
   begin
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   initial
   begin
      repeat (100000) @(posedge clk);
      failures = failures + 1;
      conclude;
   end
   initial
   begin
      failures = 0;
      cmp_count = 0;
      {rst_n, awv, wv, arv, mbit, alt, stall, dac_on} = 8'h00;
      {brdy, rrdy} = 2'h3;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      dac_val = 16'h0000;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_gain;
      t_adc(2'h0, 1'b0, 1'b1, 16'h0000);
      t_adc(2'h0, 1'b0, 1'b0, 16'h8000);
      t_adc(2'h0, 1'b1, 1'b0, 16'h4000);
      t_adc(2'h1, 1'b0, 1'b0, 16'h8000);
      t_adc(2'h2, 1'b1, 1'b1, 16'h0000);
      t_adc(2'h3, 1'b0, 1'b0, 16'h8000);
      t_adc(2'h3, 1'b0, 1'b1, 16'h0000);
      t_fifo;
      t_dac(1'b1, 16'h7FFF, 1'b1);
      t_dac(1'b1, 16'h8000, 1'b0);
      t_dac(1'b0, 16'h7FFF, 1'b1);
      t_dac(1'b0, 16'h8000, 1'b0);
      conclude;
   end
endmodule
